// ### rtl/acspc_consts.svh
// timing and code constants for the convert-start and power control block
// assumes a 20 MHz system clock
`ifndef ACSPC_CONSTS_SVH
`define ACSPC_CONSTS_SVH
`define ACSPC_CLK_NS 50
`define ACSPC_PWRUP_NS 1500
`define ACSPC_CONV_NS 4500
`define ACSPC_ACQ_NS 100
`define ACSPC_PWRUP_CYC ((`ACSPC_PWRUP_NS + `ACSPC_CLK_NS - 1) / `ACSPC_CLK_NS)
`define ACSPC_CONV_CYC ((`ACSPC_CONV_NS + `ACSPC_CLK_NS - 1) / `ACSPC_CLK_NS)
`define ACSPC_ACQ_CYC ((`ACSPC_ACQ_NS + `ACSPC_CLK_NS - 1) / `ACSPC_CLK_NS)
`define ACSPC_CODES 256
`define ACSPC_MSB_INIT 8'h80
`endif

// ### rtl/acspc_pkg.sv
// types for the convert-start and power control block
// assumes acspc_consts.svh for numbers
package acspc_pkg;
   typedef enum logic [1:0] {ST_DOWN, ST_ACQ, ST_CONV} acspc_state_t;
endpackage

// ### rtl/acspc_pulse.sv
// one-shot pulse generator: fixed-length high after a trigger
// assumes trigger is a single-cycle strobe on clk_sys
`include "acspc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module acspc_pulse #(
   parameter int LEN = `ACSPC_PWRUP_CYC
) (
   input wire logic clk_sys, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic trig, // start pulse
   output logic pulse // high for LEN cycles
);
   typedef struct packed {
      logic [15:0] cnt;
   } acspc_pl_t;
   acspc_pl_t st_r, st_nxt;
   if (LEN < 1 || LEN > 65535)
   begin : g_len_chk
      $error("acspc_pulse: bad LEN");
   end
   always_comb
   begin
      st_nxt = st_r;
      if (trig)
         st_nxt.cnt = 16'(LEN);
      else if (st_r.cnt != 16'h0000)
         st_nxt.cnt = st_r.cnt - 16'h0001;
   end
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
   assign pulse = (st_r.cnt != 16'h0000);
endmodule // acspc_pulse
`default_nettype wire

// ### rtl/acspc_top.sv
// convert-start and power control of an 8-bit successive-approximation converter
// assumes convert_start_n is an async pin; comp_hi from the analog comparator
// Operation
// - start powered down, no conversion until woken
// - convert-start rising edge powers the converter up
// - each rising edge launches 1.5 us internal pulse
// - conversion starts only on gated falling edge
// - gated signal is OR of pin and pulse
// - busy high from start until conversion end
// - sampler tracks from conversion end until start
// - 8-bit straight binary, LSB is reference/256
// - auto power-down after each conversion in mode two
// - start level at busy fall selects mode
`include "acspc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module acspc_top #(
   parameter int WIDTH = 8,
   parameter int PWRUP_CYC = `ACSPC_PWRUP_CYC,
   parameter int CONV_CYC = `ACSPC_CONV_CYC
) (
   input wire logic clk_sys, // 20 MHz clock
   input wire logic nrst, // async reset, active low
   input wire logic convert_start_n, // convert-start pin
   input wire logic comp_hi, // comparator: input at or above trial level
   output logic busy, // conversion in progress
   output logic hold, // sampler in hold
   output logic powered, // analog section powered
   output logic [WIDTH-1:0] dac_code, // trial code to the dac
   output logic [WIDTH-1:0] result, // latched conversion result
   output logic mode_fast // high-speed mode selected
);
   import acspc_pkg::*;
   // parameter limits the logic can serve
   if (WIDTH != 8)
   begin : g_width_chk
      $error("acspc_top: WIDTH must be 8");
   end
   if (CONV_CYC < WIDTH + 1)
   begin : g_conv_min_chk
      $error("acspc_top: CONV_CYC too short for the search");
   end
   if (CONV_CYC > 301)
   begin : g_conv_max_chk
      $error("acspc_top: CONV_CYC too long");
   end
   if (PWRUP_CYC < 8)
   begin : g_pwrup_min_chk
      $error("acspc_top: PWRUP_CYC too short");
   end
   if (PWRUP_CYC > 65535)
   begin : g_pwrup_max_chk
      $error("acspc_top: PWRUP_CYC too long");
   end
   localparam int CONV_LAST = CONV_CYC - 1;
   localparam logic [WIDTH-1:0] MSB_INIT = `ACSPC_MSB_INIT;

   typedef struct packed {
      logic s1;
      logic s2;
      logic gated;
      acspc_state_t state;
      logic fast;
      logic [15:0] cnt;
      logic [WIDTH-1:0] trial;
      logic [WIDTH-1:0] bitm;
      logic [WIDTH-1:0] res;
      logic busy;
   } acspc_st_t;
   acspc_st_t st_r, st_nxt;

   logic rise, pulse, gated_now, gated_fall;
   assign rise = st_r.s1 & ~st_r.s2;
   assign gated_now = st_r.s2 | pulse;
   assign gated_fall = st_r.gated & ~gated_now;

   acspc_pulse #(.LEN(PWRUP_CYC)) u_pulse (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .trig(rise),
      .pulse(pulse)
   );

   function automatic logic [WIDTH-1:0] sar_step(input logic [WIDTH-1:0] t,
      input logic [WIDTH-1:0] m, input logic keep);
      logic [WIDTH-1:0] r;
      r = keep ? t : (t & ~m);
      sar_step = r | (m >> 1);
   endfunction

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = convert_start_n;
      st_nxt.s2 = st_r.s1;
      st_nxt.gated = gated_now;
      case (st_r.state)
         ST_DOWN:
         begin
            if (rise)
               st_nxt.state = ST_ACQ;
         end
         ST_ACQ:
         begin
            if (gated_fall)
            begin
               st_nxt.state = ST_CONV;
               st_nxt.busy = 1'b1;
               st_nxt.cnt = 16'(CONV_CYC);
               st_nxt.trial = MSB_INIT;
               st_nxt.bitm = MSB_INIT;
            end
         end
         ST_CONV:
         begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
            if (st_r.bitm != '0)
            begin
               st_nxt.trial = sar_step(st_r.trial, st_r.bitm, comp_hi);
               st_nxt.bitm = st_r.bitm >> 1;
            end
            if (st_r.cnt == 16'h0001)
            begin
               st_nxt.busy = 1'b0;
               st_nxt.res = st_r.trial;
               st_nxt.fast = st_r.s2;
               st_nxt.state = st_r.s2 ? ST_ACQ : ST_DOWN;
            end
         end
         default: st_nxt.state = ST_DOWN;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r <= '0;
         st_r.state <= ST_DOWN;
      end
      else
         st_r <= st_nxt;
   end

   assign busy = st_r.busy;
   assign hold = (st_r.state == ST_CONV);
   assign powered = (st_r.state != ST_DOWN);
   assign dac_code = st_r.trial;
   assign result = st_r.res;
   assign mode_fast = st_r.fast;

   // wake and power state
   pwr_down_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r.state == ST_DOWN && !rise) |=> !busy)
      else $error("conversion without wake");
   down_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r.state == ST_DOWN) |-> (!busy && !hold && !powered))
      else $error("activity while powered down");
   down_stays_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r.state == ST_DOWN && !rise) |=> !powered)
      else $error("woke without an edge");
   wake_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r.state == ST_DOWN && rise) |=> powered)
      else $error("edge did not power up");
   pulse_len_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      rise |=> pulse [*8])
      else $error("internal pulse too short");

   // gating and conversion start
   start_edge_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(hold) |-> $past(gated_fall))
      else $error("conversion without gated fall");
   gate_or_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r.state == ST_ACQ && (pulse || st_r.s2)) |=> !hold)
      else $error("conversion while gate high");
   start_busy_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r.state == ST_ACQ && gated_fall) |=> (busy && hold))
      else $error("gated fall did not start");
   acq_wait_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r.state == ST_ACQ && !gated_fall) |=> !hold)
      else $error("hold left acquisition early");
   busy_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      busy == hold)
      else $error("busy and hold disagree");
   conv_powered_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      hold |-> powered)
      else $error("conversion while unpowered");

   // conversion sequence and result
   conv_len_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(busy) |-> (busy throughout ##CONV_LAST 1'b1) ##1 !busy)
      else $error("conversion length wrong");
   conv_runs_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r.state == ST_CONV && st_r.cnt > 16'h0001) |=> (busy && hold))
      else $error("conversion cut short");
   sar_first_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(hold) |-> (dac_code == MSB_INIT))
      else $error("search not started at midscale");
   sar_msb_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(hold) |=> (dac_code[WIDTH-1] == $past(comp_hi) && dac_code[WIDTH-2]))
      else $error("first search step wrong");
   res_latch_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $fell(busy) |-> (result == $past(dac_code)))
      else $error("result not latched at end");
   res_stable_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      busy |-> $stable(result))
      else $error("result moved during conversion");

   // operating mode
   mode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $fell(busy) |-> (mode_fast == $past(st_r.s2) && powered == mode_fast))
      else $error("mode not captured");
   mode_stable_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      busy |-> $stable(mode_fast))
      else $error("mode moved during conversion");
   fast_stay_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_r.state == ST_ACQ) |=> powered)
      else $error("powered down while acquiring");
endmodule // acspc_top
`default_nettype wire

// ### verif/acspc_host.sv
// host and comparator model at the converter's far side
// assumes the bench sets pin_req and vin just after the clock edge
`timescale 1ns/1ps
`default_nettype none
module acspc_host (
   input wire logic pin_req, // wanted pin level
   input wire logic [7:0] vin, // input level as a code
   input wire logic [7:0] dac_code, // trial code
   output logic convert_start_n, // convert-start pin
   output logic comp_hi // input at or above trial
);
   assign convert_start_n = pin_req;
   assign comp_hi = vin >= dac_code;
endmodule // acspc_host
`default_nettype wire

// ### verif/tb_acspc_top.sv
// self-checking bench for acspc_top
// assumes acspc_host as far side and shortened counts
`timescale 1ns/1ps
`default_nettype none
module tb_acspc_top;
   localparam int PW = 10;
   localparam int CV = 20;
   logic clk_sys = 0;
   logic nrst = 0;
   logic pin_req = 0;
   logic [7:0] vin = 8'h00;
   wire logic convert_start_n, comp_hi, busy, hold, powered, mode_fast;
   wire logic [7:0] dac_code, result;
   int miscompares = 0;
   int n_checks = 0;
   acspc_top #(.PWRUP_CYC(PW), .CONV_CYC(CV)) dut (.clk_sys(clk_sys), .nrst(nrst),
      .convert_start_n(convert_start_n), .comp_hi(comp_hi), .busy(busy), .hold(hold),
      .powered(powered), .dac_code(dac_code), .result(result), .mode_fast(mode_fast));
   acspc_host host (.pin_req(pin_req), .vin(vin), .dac_code(dac_code),
      .convert_start_n(convert_start_n), .comp_hi(comp_hi));
   initial forever #25 clk_sys = ~clk_sys;
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic t_idle();
      step(20);
      chk("busy", 8'h00, {7'h0, busy});
      chk("powered", 8'h00, {7'h0, powered});
   endtask
   task automatic conv(input logic [7:0] v, input int hi, input logic fast);
      int n;
      int m;
      int lo;
      logic was_hi;
      was_hi = pin_req;
      vin = v;
      pin_req = 1;
      step(hi);
      chk("powered", 8'h01, {7'h0, powered});
      pin_req = 0;
      n = hi;
      lo = (was_hi ? hi : ((hi > PW) ? hi : PW)) + 3;
      while (busy !== 1'b1 && n < 200)
      begin
         step(1);
         n++;
      end
      chk("start_cyc", 8'(lo), 8'(n));
      chk("hold", 8'h01, {7'h0, hold});
      chk("dac_first", 8'h80, dac_code);
      pin_req = fast;
      m = 0;
      while (busy === 1'b1 && m < 400)
      begin
         m++;
         step(1);
      end
      chk("busy_len", 8'(CV), 8'(m));
      chk("result", v, result);
      chk("mode_fast", {7'h0, fast}, {7'h0, mode_fast});
      chk("powered", {7'h0, fast}, {7'h0, powered});
      chk("hold", 8'h00, {7'h0, hold});
      step(3);
   endtask
   initial
   begin
      step(2);
      nrst = 1;
      t_idle();
      conv(8'h00, 5, 1'b0);
      conv(8'hff, 20, 1'b1);
      conv(8'ha5, 5, 1'b0);
      conv(8'h5a, 12, 1'b0);
      test_done();
   end
   initial
   begin
      #200000;
      miscompares++;
      test_done();
   end
endmodule // tb_acspc_top
`default_nettype wire
